// >>> hdl/irq_out_pkg.sv
// Package with constants and carrier types for the wake and fault interrupt output.
package irq_out_pkg;

    localparam int unsigned CLK_FREQ_MHZ          = 250;
    localparam int unsigned PULSE_WIDTH_US        = 100;
    localparam int unsigned PULSE_SEPARATION_US   = 100;
    localparam int unsigned PULSE_WIDTH_CYCLES    = PULSE_WIDTH_US * CLK_FREQ_MHZ;
    localparam int unsigned PULSE_SEP_CYCLES      = PULSE_SEPARATION_US * CLK_FREQ_MHZ;
    localparam int unsigned TIMER_W               = 16;

    // Wake status bit positions.
    localparam int unsigned WAKE_CAN_BIT          = 0;
    localparam int unsigned WAKE_CAN_BUS_TIMEOUT_FLAG_BIT        = 1;
    localparam int unsigned WAKE_PIN_BIT          = 2;
    localparam int unsigned WAKE_TIMER_BIT        = 3;
    localparam int unsigned WAKE_W                = 4;
    localparam int unsigned FAULT_W               = 8;

    localparam logic [WAKE_W-1:0]  WAKE_RESET   = 4'h0;
    localparam logic [FAULT_W-1:0] FAULT_RESET  = 8'h00;

    // Device operating modes, one-hot.
    typedef enum logic [5:0] {
        MODE_INIT      = 6'b000001,
        MODE_NORMAL    = 6'b000010,
        MODE_STOP      = 6'b000100,
        MODE_SLEEP     = 6'b001000,
        MODE_RESTART   = 6'b010000,
        MODE_FAILSAFE  = 6'b100000
    } dev_mode_t;

    // Pulse sequencer states, one-hot.
    typedef enum logic [2:0] {
        PS_IDLE  = 3'b001,
        PS_PULSE = 3'b010,
        PS_SEP   = 3'b100
    } pulse_state_t;

    // Wake events, one per source.
    typedef struct packed {
        logic timer;
        logic wake_pin;
        logic can_timeout;
        logic can_wake;
    } wake_evt_t;

    // Configuration seen by the interrupt logic.
    typedef struct packed {
        logic             int_global;
        logic             can_timeout_irq_mask;
        logic             gpio_is_wake;
        logic [WAKE_W-1:0] wake_enable;
        logic             gpio_wake_enable;
    } irq_cfg_t;

endpackage

// >>> hdl/wake_and_fault_interrupt_output.sv
// Interrupt output sequencer with latched wake and failure status.
//
// Function
// [R1] In Normal or Stop mode an event drives irq_out_n low for the pulse width.
// [R2] Between pulses irq_out_n stays high at least the separation time.
// [R3] A pulse never changes the device operating mode.
// [R4] Class bit 0: only latched wake status raises interrupts; secondary only if GPIO wake.
// [R5] A wake event interrupts only when its source is enabled for wake.
// [R6] CAN timeout is a wake source gated only by its own mask bit.
// [R7] Wake sources: CAN wake or timeout, wake pin, cyclic timer, GPIO wake input.
// [R8] Class bit 1: latched failure events interrupt in addition to wake events.
// [R9] Pin level, identification and selective-wake registers never raise interrupts.
// [R10] Undervoltage, watchdog, short, thermal, failure, power-on and state bits never interrupt.
// [R11] No pulses in Restart, Fail-Safe or Sleep mode; a pulse already running when the mode changes still completes.
// [R12] Entering Stop mode with any wake bit still set raises an interrupt.
// [R13] Visible status registers update at each falling edge of a pulse.
// [R14] Events stay latched until the host clears them; pin level is live.
// [R15] Host should reread a status register after clearing it to confirm.
// [R16] In Init mode the interrupt pin senses the configuration selection instead.
// [R17] Pulse width and separation are timed by counters, about 100 us each.
// [R18] Events during pulse or separation are held and signalled afterwards.
`timescale 1ns/1ps
`default_nettype none

module wake_and_fault_interrupt_output
    import irq_out_pkg::*;
(
    input  wire logic              clk_sys_i,           // System clock, 250 MHz
    input  wire logic              reset_n_i,           // Synchronous reset, active low
    input  wire dev_mode_t         dev_mode_i,          // Current operating mode
    input  wire irq_cfg_t          cfg_i,               // Class select, masks, wake enables
    input  wire wake_evt_t         wake_evt_i,          // Wake event strobes
    input  wire logic              gpio_wake_evt_i,     // GPIO wake input event strobe
    input  wire logic [FAULT_W-1:0] fault_evt_i,        // Interrupt-capable failure strobes
    input  wire logic [WAKE_W-1:0] wake_primary_clr_i,  // Host clear of primary wake bits
    input  wire logic              wake_secondary_clr_i,// Host clear of secondary wake bit
    input  wire logic [FAULT_W-1:0] fault_clr_i,        // Host clear of failure bits
    input  wire logic              irq_pin_in_i,        // Level sensed on the pin
    output logic                   irq_out_n_o,         // Pin output level, active low
    output logic                   irq_pin_oe_n_o,      // Pin output enable, active low
    output logic                   cfg_select_o,        // Configuration sensed in Init mode
    output logic [WAKE_W-1:0]      wake_status_primary_o,   // Host-visible primary wake status
    output logic                   wake_status_secondary_o, // Host-visible GPIO wake status
    output logic [FAULT_W-1:0]     fault_status_o       // Host-visible failure status
);

    // Latched events; the host-visible copies are refreshed at pulse start.
    logic [WAKE_W-1:0]  wake_lat_reg, wake_lat_next;
    logic               gpio_lat_reg, gpio_lat_next;
    logic [FAULT_W-1:0] fault_lat_reg, fault_lat_next;
    logic [WAKE_W-1:0]  wake_vis_reg, wake_vis_next;
    logic               gpio_vis_reg, gpio_vis_next;
    logic [FAULT_W-1:0] fault_vis_reg, fault_vis_next;

    pulse_state_t       state_reg, state_next;
    logic [TIMER_W-1:0] timer_reg, timer_next;
    logic               pending_reg, pending_next;
    logic               was_stop_reg, was_stop_next;
    logic               irq_n_reg, irq_n_next;
    logic               oe_n_reg, oe_n_next;
    logic               cfg_sel_reg, cfg_sel_next;

    logic [WAKE_W-1:0]  wake_en_mask;
    logic               new_event;
    logic               stop_entry;
    logic               pulse_allowed;

    // Per-source gating of the primary wake bits.
    genvar g;
    generate
        for (g = 0; g < int'(WAKE_W); g++) begin : g_wake_mask
            if (g == WAKE_CAN_BUS_TIMEOUT_FLAG_BIT) begin : g_can_bus_timeout_flag
                assign wake_en_mask[g] = cfg_i.can_timeout_irq_mask;   // see [R6]
            end else begin : g_other
                assign wake_en_mask[g] = cfg_i.wake_enable[g];         // see [R5]
            end
        end
    endgenerate

    always_comb begin
        logic [WAKE_W-1:0]  wake_set;
        logic               gpio_set;
        logic [FAULT_W-1:0] fault_set;
        wake_set  = {wake_evt_i.timer, wake_evt_i.wake_pin,
                     wake_evt_i.can_timeout, wake_evt_i.can_wake};     // see [R7]
        gpio_set  = gpio_wake_evt_i & cfg_i.gpio_is_wake;
        fault_set = fault_evt_i;                                       // see [R9] [R10]

        // Set wins over a host clear in the same cycle.
        wake_lat_next  = (wake_lat_reg & ~wake_primary_clr_i) | wake_set;      // see [R14]
        gpio_lat_next  = (gpio_lat_reg & ~wake_secondary_clr_i) | gpio_set;    // see [R14]
        fault_lat_next = (fault_lat_reg & ~fault_clr_i) | fault_set;           // see [R14]

        // The class bit is deliberately left out of the CAN timeout term.
        new_event = |(wake_set & wake_en_mask)                                 // see [R4] [R6]
                  | (gpio_set & cfg_i.gpio_wake_enable)                        // see [R4] [R5]
                  | (cfg_i.int_global & (|fault_set));                         // see [R8]

        was_stop_next = (dev_mode_i == MODE_STOP);
        stop_entry    = (dev_mode_i == MODE_STOP) && !was_stop_reg
                      && ((|wake_lat_reg) || (gpio_lat_reg && cfg_i.gpio_is_wake)); // see [R12]

        pulse_allowed = (dev_mode_i == MODE_NORMAL) || (dev_mode_i == MODE_STOP); // see [R11]
    end

    // Pulse sequencer; it only reads the mode and never drives it (see [R3]).
    always_comb begin
        state_next     = state_reg;
        timer_next     = timer_reg;
        pending_next   = pending_reg | new_event | stop_entry;          // see [R18]
        irq_n_next     = 1'b1;
        wake_vis_next  = wake_vis_reg & ~wake_primary_clr_i;
        gpio_vis_next  = gpio_vis_reg & ~wake_secondary_clr_i;
        fault_vis_next = fault_vis_reg & ~fault_clr_i;
        case (state_reg)
            PS_IDLE: begin
                if (pending_next && pulse_allowed) begin
                    state_next     = PS_PULSE;
                    timer_next     = TIMER_W'(PULSE_WIDTH_CYCLES - 1);  // see [R17]
                    pending_next   = 1'b0;
                    irq_n_next     = 1'b0;                              // see [R1]
                    wake_vis_next  = wake_lat_next;                     // see [R13]
                    gpio_vis_next  = gpio_lat_next;
                    fault_vis_next = fault_lat_next;
                end else if (!pulse_allowed) begin
                    pending_next   = 1'b0;                              // see [R11]
                end
            end
            PS_PULSE: begin
                if (timer_reg == '0) begin
                    state_next = PS_SEP;
                    timer_next = TIMER_W'(PULSE_SEP_CYCLES - 1);        // see [R2] [R17]
                end else begin
                    timer_next = timer_reg - 1'b1;
                    irq_n_next = 1'b0;                                  // see [R1]
                end
            end
            PS_SEP: begin
                if (timer_reg == '0) begin
                    state_next = PS_IDLE;                               // see [R2]
                end else begin
                    timer_next = timer_reg - 1'b1;
                end
            end
            default: begin
                state_next = PS_IDLE;
                timer_next = '0;
            end
        endcase
    end

    // Pin ownership: in Init mode the driver is released so the strap can be sensed.
    always_comb begin
        oe_n_next    = (dev_mode_i == MODE_INIT);                       // see [R16]
        cfg_sel_next = (dev_mode_i == MODE_INIT) ? irq_pin_in_i : cfg_sel_reg; // see [R16]
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            wake_lat_reg  <= WAKE_RESET;
            gpio_lat_reg  <= 1'b0;
            fault_lat_reg <= FAULT_RESET;
            wake_vis_reg  <= WAKE_RESET;
            gpio_vis_reg  <= 1'b0;
            fault_vis_reg <= FAULT_RESET;
            state_reg     <= PS_IDLE;
            timer_reg     <= '0;
            pending_reg   <= 1'b0;
            was_stop_reg  <= 1'b0;
            irq_n_reg     <= 1'b1;
            oe_n_reg      <= 1'b1;
            cfg_sel_reg   <= 1'b0;
        end else begin
            wake_lat_reg  <= wake_lat_next;
            gpio_lat_reg  <= gpio_lat_next;
            fault_lat_reg <= fault_lat_next;
            wake_vis_reg  <= wake_vis_next;
            gpio_vis_reg  <= gpio_vis_next;
            fault_vis_reg <= fault_vis_next;
            state_reg     <= state_next;
            timer_reg     <= timer_next;
            pending_reg   <= pending_next;
            was_stop_reg  <= was_stop_next;
            irq_n_reg     <= irq_n_next;
            oe_n_reg      <= oe_n_next;
            cfg_sel_reg   <= cfg_sel_next;
        end
    end

    assign irq_out_n_o             = irq_n_reg;
    assign irq_pin_oe_n_o          = oe_n_reg;
    assign cfg_select_o            = cfg_sel_reg;
    assign wake_status_primary_o   = wake_vis_reg;
    assign wake_status_secondary_o = gpio_vis_reg;
    assign fault_status_o          = fault_vis_reg;

endmodule

`default_nettype wire

// >>> test/wake_and_fault_interrupt_output_properties.sv
// Checker for interrupt pulse timing, pin use and status update.
`timescale 1ns/1ps
`default_nettype none
module irq_out_checker
    import irq_out_pkg::*;
(
    input wire logic               clk_sys_i,               // Clock
    input wire logic               reset_n_i,               // Reset
    input wire dev_mode_t          dev_mode_i,              // Mode
    input wire irq_cfg_t           cfg_i,                   // Config
    input wire wake_evt_t          wake_evt_i,              // Wake strobes
    input wire logic [FAULT_W-1:0] fault_evt_i,             // Fault strobes
    input wire logic [FAULT_W-1:0] fault_clr_i,             // Fault clears
    input wire logic [WAKE_W-1:0]  wake_primary_clr_i,      // Wake clears
    input wire logic               wake_secondary_clr_i,    // GPIO clear
    input wire logic               irq_pin_in_i,            // Pin level
    input wire logic               irq_out_n_o,             // Pulse
    input wire logic               irq_pin_oe_n_o,          // Enable
    input wire logic               cfg_select_o,            // Config sensed
    input wire logic [WAKE_W-1:0]  wake_status_primary_o,   // Status
    input wire logic               wake_status_secondary_o, // Status
    input wire logic [FAULT_W-1:0] fault_status_o           // Status
);
    logic [15:0] low_cnt_reg;
    logic [15:0] low_cnt_next;
    logic [15:0] high_cnt_reg;
    logic [15:0] high_cnt_next;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    // The high counter saturates so that a long idle time still reads as enough separation.
    always_comb begin
        low_cnt_next = irq_out_n_o ? 16'h0000 : low_cnt_reg + 16'h0001;
        high_cnt_next = !irq_out_n_o ? 16'h0000 : high_cnt_reg + {15'h0000, high_cnt_reg != 16'hffff};
    end
    always_ff @(posedge clk_sys_i) begin
        low_cnt_reg <= reset_n_i ? low_cnt_next : 16'h0000;
        high_cnt_reg <= reset_n_i ? high_cnt_next : 16'hffff;
    end
    property p_width; $rose(irq_out_n_o) |-> low_cnt_reg == PULSE_WIDTH_CYCLES; endproperty
    a_width: assert property (p_width) else $error("pulse width wrong");
    property p_sep; $fell(irq_out_n_o) |-> high_cnt_reg >= PULSE_SEP_CYCLES; endproperty
    a_sep: assert property (p_sep) else $error("pulses too close");
    property p_mode; $fell(irq_out_n_o) |-> $past(dev_mode_i) inside {MODE_NORMAL, MODE_STOP}; endproperty
    a_mode: assert property (p_mode) else $error("pulse in quiet mode");
    property p_oe; dev_mode_i != MODE_INIT |=> !irq_pin_oe_n_o; endproperty
    a_oe: assert property (p_oe) else $error("pin not driven");
    property p_cfg; dev_mode_i == MODE_INIT |=> cfg_select_o == $past(irq_pin_in_i); endproperty
    a_cfg: assert property (p_cfg) else $error("config not sensed");
    property p_status;
        $changed({wake_status_primary_o, wake_status_secondary_o, fault_status_o})
            && !$past(|{wake_primary_clr_i, wake_secondary_clr_i, fault_clr_i}) |-> $fell(irq_out_n_o);
    endproperty
    a_status: assert property (p_status) else $error("status moved off pulse edge");
    property p_clear; fault_clr_i == 8'hff && fault_evt_i == 8'h00 && !irq_out_n_o |=> fault_status_o == 8'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("clear ignored");
    property p_delay;
        wake_evt_i.timer && cfg_i.wake_enable[WAKE_TIMER_BIT] && dev_mode_i == MODE_NORMAL
            && high_cnt_reg > 16'h7000 |-> ##1 !irq_out_n_o;
    endproperty
    a_delay: assert property (p_delay) else $error("enabled wake gave no pulse");
endmodule
bind wake_and_fault_interrupt_output irq_out_checker i_irq_out_checker (.*);
`default_nettype wire

// >>> test/host_irq_model.sv
// Host side of the interrupt pin: resolves the wire and counts pulses.
`timescale 1ns/1ps
`default_nettype none
module host_irq_model (
    input  wire logic irq_out_n_i, // Device output level
    input  wire logic irq_oe_n_i,  // Device enable, low drives
    input  wire logic strap_i,     // Board strap level
    output logic      pin_o,       // Wire level
    output logic [7:0] falls_o     // Pulses seen
);
    // A released pin shows only the board strap, never the last driven value.
    assign pin_o = irq_oe_n_i ? strap_i : irq_out_n_i;
    initial falls_o = 8'h00;
    always @(negedge irq_out_n_i) if (!irq_oe_n_i) falls_o <= falls_o + 8'h01;
endmodule
`default_nettype wire

// >>> test/wake_and_fault_interrupt_output_test.sv
// Self-checking bench for the interrupt output sequencer.
`timescale 1ns/1ps
`default_nettype none
module wake_and_fault_interrupt_output_test;
    import irq_out_pkg::*;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    dev_mode_t dev_mode_i = MODE_INIT;
    irq_cfg_t cfg_i = '0;
    wake_evt_t wake_evt_i = '0;
    logic gpio_wake_evt_i = 1'b0;
    logic [FAULT_W-1:0] fault_evt_i = '0;
    logic [FAULT_W-1:0] fault_clr_i = '0;
    logic [WAKE_W-1:0] wake_primary_clr_i = '0;
    logic wake_secondary_clr_i = 1'b0;
    logic strap = 1'b0;
    logic pin, irq_out_n_o, irq_pin_oe_n_o, cfg_select_o, wake_status_secondary_o;
    logic [WAKE_W-1:0] wake_status_primary_o;
    logic [FAULT_W-1:0] fault_status_o;
    logic [7:0] falls;
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int n;
    always #2 clk_sys_i = ~clk_sys_i;
    wake_and_fault_interrupt_output i_wake_and_fault_interrupt_output (.clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i), .dev_mode_i(dev_mode_i), .cfg_i(cfg_i), .wake_evt_i(wake_evt_i),
        .gpio_wake_evt_i(gpio_wake_evt_i), .fault_evt_i(fault_evt_i), .wake_primary_clr_i(wake_primary_clr_i),
        .wake_secondary_clr_i(wake_secondary_clr_i), .fault_clr_i(fault_clr_i), .irq_pin_in_i(pin),
        .irq_out_n_o(irq_out_n_o), .irq_pin_oe_n_o(irq_pin_oe_n_o), .cfg_select_o(cfg_select_o),
        .wake_status_primary_o(wake_status_primary_o), .wake_status_secondary_o(wake_status_secondary_o),
        .fault_status_o(fault_status_o));
    host_irq_model i_host_irq_model (.irq_out_n_i(irq_out_n_o), .irq_oe_n_i(irq_pin_oe_n_o),
        .strap_i(strap), .pin_o(pin), .falls_o(falls));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cycles(input int k);
        repeat (k) @(negedge clk_sys_i);
    endtask
    task automatic measure(input logic lvl, input int start);
        n = start;
        while (irq_out_n_o === lvl && n < 30000) begin
            n++;
            @(negedge clk_sys_i);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic t_sleep();
        @(posedge clk_sys_i);
        dev_mode_i <= MODE_SLEEP;
        cfg_i.wake_enable <= 4'h8;
        wake_evt_i.timer <= 1'b1;
        @(posedge clk_sys_i);
        wake_evt_i.timer <= 1'b0;
        cycles(20);
        check("sleep pulses", 16'(falls), 16'h0000);
        $display("test sleep done");
    endtask
    task automatic t_refuse();
        @(posedge clk_sys_i);
        dev_mode_i <= MODE_NORMAL;
        fault_evt_i <= 8'h01;
        wake_evt_i.wake_pin <= 1'b1;
        gpio_wake_evt_i <= 1'b1;
        @(posedge clk_sys_i);
        fault_evt_i <= 8'h00;
        wake_evt_i.wake_pin <= 1'b0;
        gpio_wake_evt_i <= 1'b0;
        cycles(20);
        check("refused pulses", 16'(falls), 16'h0000);
        @(posedge clk_sys_i);
        fault_clr_i <= 8'hff;
        wake_primary_clr_i <= 4'hf;
        wake_secondary_clr_i <= 1'b1;
        @(posedge clk_sys_i);
        fault_clr_i <= 8'h00;
        wake_primary_clr_i <= 4'h0;
        wake_secondary_clr_i <= 1'b0;
        $display("test refuse done");
    endtask
    task automatic t_pulse();
        @(posedge clk_sys_i);
        wake_evt_i.timer <= 1'b1;
        @(posedge clk_sys_i);
        wake_evt_i.timer <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        cycles(1);
        check("pulse start", 16'(irq_out_n_o), 16'h0000);
        check("timer status", 16'(wake_status_primary_o[WAKE_TIMER_BIT]), 16'h0001);
        @(posedge clk_sys_i);
        cfg_i.int_global <= 1'b1;
        fault_evt_i <= 8'h20;
        @(posedge clk_sys_i);
        fault_evt_i <= 8'h00;
        cycles(1);
        // Four low cycles have already passed when the count starts.
        measure(1'b0, 4);
        check("pulse width", 16'(n), 16'(PULSE_WIDTH_CYCLES));
        measure(1'b1, 0);
        check("separation", 16'(n >= PULSE_SEP_CYCLES), 16'h0001);
        check("held fault", 16'(fault_status_o[5]), 16'h0001);
        check("pulse count", 16'(falls), 16'h0002);
        @(posedge clk_sys_i);
        fault_clr_i <= 8'hff;
        @(posedge clk_sys_i);
        fault_clr_i <= 8'h00;
        cycles(1);
        check("cleared", 16'(fault_status_o), 16'h0000);
        cycles(2);
        check("reread", 16'(fault_status_o), 16'h0000);
        $display("test pulse done");
    endtask
    // A reset in mid-pulse keeps the run short; the wake is latched in Sleep, then Stop is entered.
    task automatic t_stop();
        @(posedge clk_sys_i);
        reset_n_i <= 1'b0;
        dev_mode_i <= MODE_SLEEP;
        repeat (2) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        @(posedge clk_sys_i);
        wake_evt_i.timer <= 1'b1;
        @(posedge clk_sys_i);
        wake_evt_i.timer <= 1'b0;
        dev_mode_i <= MODE_STOP;
        cycles(3);
        check("stop entry", 16'({irq_out_n_o, falls}), 16'h0003);
        check("stop status", 16'(wake_status_primary_o), 16'h0008);
        $display("test stop done");
    endtask
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fail_count++;
            summarize();
        end
    end
    initial begin
        repeat (12) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        cycles(1);
        check("reset out", 16'({irq_out_n_o, cfg_select_o, fault_status_o}), 16'h0200);
        @(posedge clk_sys_i);
        strap <= 1'b1;
        cycles(3);
        check("init sense", 16'({irq_pin_oe_n_o, cfg_select_o}), 16'h0003);
        t_sleep();
        t_refuse();
        t_pulse();
        t_stop();
        summarize();
    end
endmodule
`default_nettype wire
